// ### logic/rdt_result_path.sv
// Purpose: remote diode excitation sequence, averaging, coding and registers
// Assumes: converter returns one signed quarter-degree sample per request
// Notes:   APB slave, one wait-free access cycle, pslverr on unmapped words
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module rdt_result_path
#(parameter int PHASE_CYC_P = rdt_pkg::PHASE_CYC)
(
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [rdt_pkg::APB_AW-1:0]   paddr,
    input  wire logic [rdt_pkg::APB_DW-1:0]   pwdata,
    output logic      [rdt_pkg::APB_DW-1:0]   prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic      [1:0]                   exc_sel,
    output logic                              exc_channel,
    output logic                              adc_start,
    input  wire logic                         adc_valid,
    input  wire logic [rdt_pkg::SAMPLE_W-1:0] adc_sample
);
    import rdt_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    rdt_avg_if av ();
    rdt_averager #(.N_AVG_P(N_AVG)) u_avg (
        .pclk    (pclk),
        .presetn (presetn),
        .av      (av)
    );

    rdt_state_t          st;
    logic [PCNT_W-1:0]   phase_cnt;
    logic [3:0]          meas_cnt;
    logic                res_ch;
    logic [7:0]          trim1;
    logic [7:0]          trim2;
    logic [7:0]          cfg;
    logic [7:0]          ctrl;
    logic [CODE_W-1:0]   vis1;
    logic [CODE_W-1:0]   vis2;
    logic [CODE_W-1:0]   shadow1;
    logic [CODE_W-1:0]   shadow2;
    logic                pend1;
    logic                pend2;
    logic                freeze;
    logic                seen1;
    logic                seen2;
    logic [CODE_W-1:0]   fmt_code;
    logic [APB_DW-1:0]   rd_val;
    logic [7:0]          idx;
    logic                word_ok;
    logic                acc;
    logic                wr_acc;
    logic                rd_frac;
    logic                rd_t1;
    logic                rd_t2;
    logic                enable;
    logic                phase_end;
    logic                res1;
    logic                res2;
    logic                wr1;
    logic                wr2;

    assign idx       = paddr[9:2];
    assign word_ok   = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    assign acc       = psel && penable && pready;
    assign wr_acc    = acc && pwrite && !pslverr;
    assign rd_frac   = acc && !pwrite && (idx == IDX_FRAC);
    assign rd_t1     = acc && !pwrite && (idx == IDX_TEMP1);
    assign rd_t2     = acc && !pwrite && (idx == IDX_TEMP2);
    assign enable    = ctrl[CTRL_EN_BIT];
    assign phase_end = (phase_cnt == PCNT_W'(PHASE_CYC_P - 1));

    // R07 R09 R10 R15 trim and range coding
    assign fmt_code = rdt_fmt(av.result, res_ch ? trim2 : trim1, cfg[CFG_TWOS_BIT]);

    assign res1 = av.result_valid && !res_ch;
    assign res2 = av.result_valid && res_ch;
    assign wr1  = res1 ? !freeze : (pend1 && !freeze);
    assign wr2  = res2 ? !freeze : (pend2 && !freeze);

    // excitation sequence state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st        <= S_IDLE;
            phase_cnt <= '0;
        end
        else
        begin
            case (st)
                S_IDLE:
                begin
                    phase_cnt <= '0;
                    if (enable)
                        st <= S_BASE1;
                end
                // R01 base then first multiple
                S_BASE1, S_MULT1, S_BASE2, S_MULT2:
                begin
                    phase_cnt <= phase_end ? '0 : phase_cnt + PCNT_W'(1);
                    if (!enable)
                        st <= S_IDLE;
                    else if (phase_end)
                        st <= (st == S_BASE1) ? S_MULT1 :
                              (st == S_MULT1) ? S_BASE2 :
                              (st == S_BASE2) ? S_MULT2 : S_CONV;
                end
                S_CONV:
                begin
                    if (adc_valid)
                        st <= enable ? S_BASE1 : S_IDLE;
                end
                default:
                    st <= S_IDLE;
            endcase
        end
    end

    // R02 current select per phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exc_sel   <= EXC_OFF;
            adc_start <= 1'b0;
        end
        else
        begin
            case (st)
                S_BASE1, S_BASE2: exc_sel <= EXC_BASE;
                S_MULT1:          exc_sel <= EXC_MID;
                S_MULT2:          exc_sel <= EXC_HIGH;
                default:          exc_sel <= EXC_OFF;
            endcase
            adc_start <= (st == S_MULT2) && phase_end && enable;
        end
    end

    // R03 sample dispatch and channel turn
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meas_cnt        <= '0;
            exc_channel     <= 1'b0;
            res_ch          <= 1'b0;
            av.sample       <= '0;
            av.sample_valid <= 1'b0;
            av.clear        <= 1'b0;
        end
        else
        begin
            av.sample_valid <= 1'b0;
            av.clear        <= 1'b0;
            if (st == S_IDLE)
            begin
                meas_cnt     <= '0;
                av.clear     <= 1'b1;
            end
            else if ((st == S_CONV) && adc_valid)
            begin
                av.sample       <= adc_sample;
                av.sample_valid <= 1'b1;
                if (meas_cnt == 4'(N_AVG - 1))
                begin
                    meas_cnt    <= '0;
                    res_ch      <= exc_channel;
                    exc_channel <= !exc_channel;
                end
                else
                    meas_cnt <= meas_cnt + 4'h1;
            end
        end
    end

    // R12 R04 whole result commit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vis1    <= RST_CODE;
            vis2    <= RST_CODE;
            shadow1 <= RST_CODE;
            shadow2 <= RST_CODE;
            pend1   <= 1'b0;
            pend2   <= 1'b0;
        end
        else
        begin
            if (res1)
                shadow1 <= fmt_code;
            if (res2)
                shadow2 <= fmt_code;
            if (wr1)
                vis1 <= res1 ? fmt_code : shadow1;
            if (wr2)
                vis2 <= res2 ? fmt_code : shadow2;
            // R14 new result wins over release
            pend1 <= res1 ? freeze : (pend1 && freeze);
            pend2 <= res2 ? freeze : (pend2 && freeze);
        end
    end

    // R14 freeze on fraction read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            freeze <= 1'b0;
            seen1  <= 1'b0;
            seen2  <= 1'b0;
        end
        else if (rd_frac)
        begin
            freeze <= 1'b1;
            seen1  <= 1'b0;
            seen2  <= 1'b0;
        end
        else
        begin
            if (rd_t1)
                seen1 <= 1'b1;
            if (rd_t2)
                seen2 <= 1'b1;
            if ((seen1 || rd_t1) && (seen2 || rd_t2))
                freeze <= 1'b0;
        end
    end

    // R08 writable registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trim1 <= RST_TRIM;
            trim2 <= RST_TRIM;
            cfg   <= RST_CFG;
            ctrl  <= RST_CTRL;
        end
        else if (wr_acc)
        begin
            case (idx)
                IDX_TRIM1: trim1 <= pwdata[7:0];
                IDX_TRIM2: trim2 <= pwdata[7:0];
                IDX_CFG:   cfg   <= pwdata[7:0];
                IDX_CTRL:  ctrl  <= {7'h00, pwdata[CTRL_EN_BIT]};
                default:   ;
            endcase
        end
    end

    // R05 R06 R13 read layout
    always_comb
    begin
        rd_val = '0;
        case (idx)
            IDX_TEMP1: rd_val[7:0] = vis1[CODE_W-1:2];
            IDX_TEMP2: rd_val[7:0] = vis2[CODE_W-1:2];
            IDX_TRIM1: rd_val[7:0] = trim1;
            IDX_TRIM2: rd_val[7:0] = trim2;
            IDX_FRAC:
            begin
                rd_val[FRAC_R2_LSB +: 2]  = vis2[1:0];
                rd_val[FRAC_LOC_LSB +: 2] = 2'h0;
                rd_val[FRAC_R1_LSB +: 2]  = vis1[1:0];
            end
            IDX_CFG:   rd_val[7:0] = cfg;
            IDX_CTRL:
            begin
                rd_val[CTRL_EN_BIT]     = ctrl[CTRL_EN_BIT];
                rd_val[CTRL_FREEZE_BIT] = freeze;
                rd_val[CTRL_BUSY_BIT]   = (st != S_IDLE);
                rd_val[CTRL_CH_BIT]     = exc_channel;
            end
            default:   rd_val = '0;
        endcase
    end

    // apb answer, one access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata  <= (word_ok && !pwrite) ? rd_val : '0;
            pready  <= 1'b1;
            pslverr <= !(word_ok && rdt_mapped(idx));
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // helper: samples seen since last result
    logic [4:0] samp_seen;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            samp_seen <= '0;
        else if (av.clear || av.result_valid)
            samp_seen <= '0;
        else if (av.sample_valid)
            samp_seen <= samp_seen + 5'h01;
    end

    property p_seq_order;
        (st == S_MULT1) && ($past(st) != S_MULT1) |-> $past(st) == S_BASE1;
    endproperty
    a_seq_order: assert property (p_seq_order) else $error("first multiple without base"); // R01
    property p_high_cur;
        (st == S_MULT2) ##1 (st == S_MULT2) |-> exc_sel == EXC_HIGH;
    endproperty
    a_high_cur: assert property (p_high_cur) else $error("high current not driven"); // R02
    property p_avg_count;
        av.result_valid |-> (samp_seen == 5'h10) && !av.sample_valid;
    endproperty
    a_avg_count: assert property (p_avg_count) else $error("result not after 16 samples"); // R03
    property p_frac_layout;
        acc && !pwrite && (idx == IDX_FRAC) |->
            prdata[7:6] == $past(vis2[1:0]) && prdata[3:2] == $past(vis1[1:0]) &&
            prdata[5:4] == 2'h0;
    endproperty
    a_frac_layout: assert property (p_frac_layout) else $error("fraction layout wrong"); // R13
    property p_commit;
        res1 && !freeze |=> vis1 == $past(fmt_code);
    endproperty
    a_commit: assert property (p_commit) else $error("result not stored"); // R09
    property p_frozen;
        $past(freeze) |-> $stable(vis1) && $stable(vis2);
    endproperty
    a_frozen: assert property (p_frozen) else $error("reading changed while frozen"); // R14
    property p_release;
        freeze && pend2 ##1 !freeze && !res2 |=> vis2 == $past(shadow2);
    endproperty
    a_release: assert property (p_release) else $error("held result lost"); // R12
    property p_zero_trim;
        av.result_valid && (fmt_code != 10'h000) && (fmt_code != 10'h3FF) &&
        !cfg[CFG_TWOS_BIT] |->
            fmt_code == 10'(av.result + 12'sh100 +
                            12'sh002 * 12'($signed(res_ch ? trim2 : trim1)));
    endproperty
    a_zero_trim: assert property (p_zero_trim) else $error("offset-64 coding wrong"); // R07
    property p_twos_clamp;
        av.result_valid && cfg[CFG_TWOS_BIT] && (av.result < 12'shD00) |-> fmt_code == 10'h200;
    endproperty
    a_twos_clamp: assert property (p_twos_clamp) else $error("two's complement floor wrong"); // R15
    property p_trim_wr;
        wr_acc && (idx == IDX_TRIM2) |=> trim2 == $past(pwdata[7:0]);
    endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim write lost"); // R08

    c_commit:  cover property (res1 && !freeze);
    c_release: cover property (freeze ##1 !freeze);
    c_twos:    cover property (av.result_valid && cfg[CFG_TWOS_BIT]);

endmodule : rdt_result_path

// ### logic/rdt_pkg.sv
// Purpose: constants, types and helpers of the remote diode result path
// Assumes: 25 MHz pclk, APB register access, on-chip converter on pclk
// Notes:   register indices are word indices, byte address is index * 4
//
// Functional notes
// R01: sequence base/first, then base/second multiple currents
// R02: high current 96 uA, low 6 uA
// R03: average 16 measurement cycles per result
// R04: results are 10-bit quarter-degree values
// R05: two low bits go to fraction register
// R06: normal range: whole degrees plus quarter bits
// R07: extended range: unsigned offset-64 coding
// R08: separate writable trim per remote channel
// R09: add signed 8-bit trim to each result
// R10: trim LSB weighs half a degree
// R11: software writes summed corrections as one trim
// R12: value and fraction update together when complete
// R13: fraction bits at 7:6, 5:4, 3:2
// R14: fraction read freezes readings until all read
// R15: config bit 1 selects two's complement storage
package rdt_pkg;

    localparam int APB_AW   = 12;
    localparam int APB_DW   = 32;
    localparam int SAMPLE_W = 12;
    localparam int CODE_W   = 10;
    localparam int N_AVG    = 16;

    // timing: each excitation phase
    localparam int CLK_MHZ   = 25;
    localparam int PHASE_US  = 100;
    localparam int PHASE_CYC = PHASE_US * CLK_MHZ;
    localparam int PCNT_W    = 12;

    // excitation currents and select codes
    localparam int         CUR_LOW_UA  = 6;
    localparam int         CUR_HIGH_UA = 96;
    localparam logic [1:0] EXC_OFF     = 2'h0;
    localparam logic [1:0] EXC_BASE    = 2'h1;
    localparam logic [1:0] EXC_MID     = 2'h2;
    localparam logic [1:0] EXC_HIGH    = 2'h3;

    // register indices
    localparam logic [7:0] IDX_TEMP1 = 8'h25;
    localparam logic [7:0] IDX_TEMP2 = 8'h27;
    localparam logic [7:0] IDX_TRIM1 = 8'h70;
    localparam logic [7:0] IDX_TRIM2 = 8'h72;
    localparam logic [7:0] IDX_FRAC  = 8'h77;
    localparam logic [7:0] IDX_CFG   = 8'h7C;
    localparam logic [7:0] IDX_CTRL  = 8'h7E;

    // field positions
    localparam int CFG_TWOS_BIT    = 1;
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_FREEZE_BIT = 1;
    localparam int CTRL_BUSY_BIT   = 2;
    localparam int CTRL_CH_BIT     = 3;
    localparam int FRAC_R2_LSB     = 6;
    localparam int FRAC_LOC_LSB    = 4;
    localparam int FRAC_R1_LSB     = 2;

    // reset values
    localparam logic [7:0]        RST_TRIM = 8'h00;
    localparam logic [7:0]        RST_CFG  = 8'h00;
    localparam logic [7:0]        RST_CTRL = 8'h00;
    localparam logic [CODE_W-1:0] RST_CODE = 10'h000;

    // code limits in quarter degrees
    localparam logic signed [13:0] EXT_BIAS = 14'sh0100;
    localparam logic signed [13:0] TWOS_LO  = 14'sh3E00;
    localparam logic signed [13:0] TWOS_HI  = 14'sh01FF;
    localparam logic signed [13:0] EXT_HI   = 14'sh03FF;

    typedef enum logic [5:0] {
        S_IDLE  = 6'h01,
        S_BASE1 = 6'h02,
        S_MULT1 = 6'h04,
        S_BASE2 = 6'h08,
        S_MULT2 = 6'h10,
        S_CONV  = 6'h20
    } rdt_state_t;

    function automatic logic rdt_mapped(input logic [7:0] idx);
        rdt_mapped = (idx == IDX_TEMP1) || (idx == IDX_TEMP2) || (idx == IDX_TRIM1) ||
                     (idx == IDX_TRIM2) || (idx == IDX_FRAC)  || (idx == IDX_CFG)   ||
                     (idx == IDX_CTRL);
    endfunction : rdt_mapped

    // trim add, range coding and saturation
    function automatic logic [CODE_W-1:0] rdt_fmt(input logic signed [SAMPLE_W-1:0] avg,
                                                  input logic [7:0]                 trim,
                                                  input logic                       twos);
        logic signed [13:0] v;
        v = 14'(avg) + 14'($signed({trim, 1'b0}));
        if (!twos)
            v = v + EXT_BIAS;
        if (twos)
        begin
            if (v < TWOS_LO)
                rdt_fmt = 10'h200;
            else if (v > TWOS_HI)
                rdt_fmt = 10'h1FF;
            else
                rdt_fmt = v[CODE_W-1:0];
        end
        else if (v < 14'sh0000)
            rdt_fmt = 10'h000;
        else if (v > EXT_HI)
            rdt_fmt = 10'h3FF;
        else
            rdt_fmt = v[CODE_W-1:0];
    endfunction : rdt_fmt

endpackage : rdt_pkg

// ### logic/rdt_avg_if.sv
// Purpose: link between sequencer and averager
// Assumes: both ends on pclk
// Notes:   result_valid is a one-cycle pulse
`timescale 1ns/1ps
interface rdt_avg_if;
    import rdt_pkg::*;
    logic signed [SAMPLE_W-1:0] sample;
    logic                       sample_valid;
    logic                       clear;
    logic signed [SAMPLE_W-1:0] result;
    logic                       result_valid;
    modport avg (input sample, sample_valid, clear, output result, result_valid);
    modport seq (output sample, sample_valid, clear, input result, result_valid);
endinterface : rdt_avg_if

// ### logic/rdt_averager.sv
// Purpose: boxcar average over a fixed number of samples
// Assumes: n_avg is a power of two
// Notes:   result is the arithmetic-shifted sum
`timescale 1ns/1ps
module rdt_averager
    import rdt_pkg::*;
#(
    parameter int N_AVG_P = N_AVG
)
(
    input wire logic pclk,
    input wire logic presetn,
    rdt_avg_if.avg   av
);
    localparam int SH = $clog2(N_AVG_P);

    logic signed [SAMPLE_W+SH-1:0] acc;
    logic signed [SAMPLE_W+SH-1:0] next_acc;
    logic        [SH-1:0]          cnt;

    assign next_acc = acc + (SAMPLE_W+SH)'(av.sample);

    // R03 sixteen sample average
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc             <= '0;
            cnt             <= '0;
            av.result       <= '0;
            av.result_valid <= 1'b0;
        end
        else
        begin
            av.result_valid <= 1'b0;
            if (av.clear)
            begin
                acc <= '0;
                cnt <= '0;
            end
            else if (av.sample_valid)
            begin
                if (cnt == SH'(N_AVG_P - 1))
                begin
                    av.result       <= SAMPLE_W'(next_acc >>> SH);
                    av.result_valid <= 1'b1;
                    acc             <= '0;
                    cnt             <= '0;
                end
                else
                begin
                    acc <= next_acc;
                    cnt <= cnt + SH'(1);
                end
            end
        end
    end

endmodule : rdt_averager

// ### tb/rdt_diode_model.sv
// Purpose: converter and remote diode stand-in for the result path
// Assumes: one signed quarter-degree sample per conversion request
// Notes:   answer delay alternates prompt and slow; samples alternate +-3
`timescale 1ns/1ps
module rdt_diode_model
    import rdt_pkg::*;
#(
    parameter int T1Q = 0,
    parameter int T2Q = 0
)
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [1:0]          exc_sel,
    input  wire logic                exc_channel,
    input  wire logic                adc_start,
    output logic                     adc_valid,
    output logic [SAMPLE_W-1:0]      adc_sample,
    output logic [7:0]               n_conv,
    output logic [7:0]               n_bad
);
    logic [1:0] prev_sel;
    logic [7:0] hist;
    logic [3:0] dly;
    logic       chan;
    logic       busy;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_sel <= EXC_OFF;
            hist <= 8'h00;
            n_bad <= 8'h00;
        end
        else
        begin
            prev_sel <= exc_sel;
            if (exc_sel != prev_sel && exc_sel != EXC_OFF)
                hist <= {hist[5:0], exc_sel};
            if (adc_start && hist != {EXC_BASE, EXC_MID, EXC_BASE, EXC_HIGH})
                n_bad <= n_bad + 8'h01;
        end
    end

    // released data line toggles, never holds the last sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            dly <= 4'h0;
            chan <= 1'b0;
            n_conv <= 8'h00;
            adc_valid <= 1'b0;
            adc_sample <= 12'h000;
        end
        else
        begin
            adc_valid <= 1'b0;
            adc_sample <= ~adc_sample;
            if (adc_start)
            begin
                busy <= 1'b1;
                chan <= exc_channel;
                dly <= n_conv[0] ? 4'h7 : 4'h0;
            end
            else if (busy && dly != 4'h0)
                dly <= dly - 4'h1;
            else if (busy)
            begin
                busy <= 1'b0;
                adc_valid <= 1'b1;
                adc_sample <= 12'((chan ? T2Q : T1Q) + (n_conv[0] ? 3 : -3));
                n_conv <= n_conv + 8'h01;
            end
        end
    end
endmodule : rdt_diode_model

// ### tb/rdt_result_path_test.sv
// Purpose: self-checking bench of the remote diode result path
// Assumes: full 16-sample averaging, so one result per channel is run
// Notes:   short excitation phases keep the run near 7k cycles
`timescale 1ns/1ps
module rdt_result_path_test;
    import rdt_pkg::*;
    localparam int T1Q = -101;
    localparam int T2Q = 401;
    localparam int TR1 = -3;
    localparam int TR2 = 4;
    localparam logic [9:0] C1 = 10'(T1Q + 2 * TR1);
    localparam logic [9:0] C2 = 10'(T2Q + 2 * TR2 + 256);
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic adc_start, adc_valid, exc_channel;
    logic [11:0] paddr, adc_sample;
    logic [31:0] pwdata, prdata;
    logic [1:0] exc_sel;
    logic [7:0] n_conv, n_bad;
    int num_errors, compares, cyc;

    rdt_result_path #(.PHASE_CYC_P(50)) i_rdt_result_path (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exc_sel, .exc_channel,
        .adc_start, .adc_valid, .adc_sample);
    rdt_diode_model #(.T1Q(T1Q), .T2Q(T2Q)) i_rdt_diode_model (.pclk, .presetn, .exc_sel,
        .exc_channel, .adc_start, .adc_valid, .adc_sample, .n_conv, .n_bad);

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    function automatic logic [11:0] ba(input logic [7:0] idx);
        ba = {2'b00, idx, 2'b00};
    endfunction : ba

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [32:0] res);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        res = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic ee);
        logic [32:0] r;
        apb(1'b0, ba(idx), 32'h0, r);
        chk(r, {ee, 24'h0, exp});
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic ee);
        logic [32:0] r;
        apb(1'b1, a, {24'h0, d}, r);
        chk({r[32], 32'h0}, {ee, 32'h0});
    endtask : wr

    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            $display("[ERR] %0t run too long", $time);
            complete_run();
        end
    end

    initial
    begin
        num_errors = 0;
        compares = 0;
        cyc = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        wr(ba(IDX_FRAC), 8'hFF, 1'b0);
        rd(IDX_FRAC, 8'h00, 1'b0);
        rd(IDX_TEMP1, 8'h00, 1'b0);
        rd(IDX_TEMP2, 8'h00, 1'b0);
        rd(IDX_TRIM1, 8'h00, 1'b0);
        rd(IDX_TRIM2, 8'h00, 1'b0);
        rd(IDX_CFG, 8'h00, 1'b0);
        wr(ba(IDX_TRIM1), 8'(-2 - 1), 1'b0);
        wr(ba(IDX_TRIM2), 8'(TR2), 1'b0);
        rd(IDX_TRIM1, 8'(TR1), 1'b0);
        rd(IDX_TRIM2, 8'(TR2), 1'b0);
        wr(ba(8'h71), 8'h55, 1'b1);
        rd(8'h71, 8'h00, 1'b1);
        wr(ba(IDX_TRIM1) + 12'h001, 8'h00, 1'b1);
        rd(IDX_TRIM1, 8'(TR1), 1'b0);
        wr(ba(IDX_CFG), 8'h02, 1'b0);
        rd(IDX_CFG, 8'h02, 1'b0);
        $display("test registers done");
        wr(ba(IDX_CTRL), 8'h01, 1'b0);
        while (n_conv < 8'd16)
            @(posedge pclk);
        repeat (10) @(posedge pclk);
        rd(IDX_TEMP1, C1[9:2], 1'b0);
        wr(ba(IDX_CFG), 8'h00, 1'b0);
        rd(IDX_FRAC, {4'h0, C1[1:0], 2'b00}, 1'b0);
        while (n_conv < 8'd32)
            @(posedge pclk);
        repeat (10) @(posedge pclk);
        rd(IDX_TEMP2, 8'h00, 1'b0);
        rd(IDX_TEMP1, C1[9:2], 1'b0);
        rd(IDX_TEMP2, C2[9:2], 1'b0);
        rd(IDX_FRAC, {C2[1:0], 2'b00, C1[1:0], 2'b00}, 1'b0);
        chk({25'h0, n_bad}, 33'h0);
        $display("test results done");
        complete_run();
    end
endmodule : rdt_result_path_test
